//--- pkg/rsp_pkg.sv
// Constants and types for the shared-line serial port with setup-tool port
package rsp_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ        = 25_000_000;
  localparam int BAUD_LO       = 19200;
  localparam int BAUD_MID      = 38400;
  localparam int BAUD_HI       = 57600;
  localparam int TOOL_BAUD     = 38400;
  localparam int DIV_W         = 11;
  localparam logic [DIV_W-1:0] DIV_LO   = DIV_W'(CLK_HZ / BAUD_LO);
  localparam logic [DIV_W-1:0] DIV_MID  = DIV_W'(CLK_HZ / BAUD_MID);
  localparam logic [DIV_W-1:0] DIV_HI   = DIV_W'(CLK_HZ / BAUD_HI);
  localparam logic [DIV_W-1:0] DIV_TOOL = DIV_W'(CLK_HZ / TOOL_BAUD);
  localparam int MS_PER_S      = 1000;
  localparam int CYC_PER_MS    = CLK_HZ / MS_PER_S;
  localparam logic [6:0] DELAY_MAX_MS = 7'h63;
  localparam logic [6:0] DELAY_RST_MS = 7'h14;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [4:0] ADDR_CONFIG = 5'h00;
  localparam logic [4:0] ADDR_STATUS = 5'h04;
  localparam logic [4:0] ADDR_DATA   = 5'h08;
  localparam logic [4:0] ADDR_CHECK  = 5'h0c;
  localparam logic [4:0] ADDR_TOOL   = 5'h10;

  // CONFIG fields
  localparam int CF_BAUD_LSB  = 0;
  localparam int CF_DATA8     = 2;
  localparam int CF_STOP2     = 3;
  localparam int CF_PAR_LSB   = 4;
  localparam int CF_CRC       = 6;
  localparam int CF_DELAY_LSB = 8;

  // STATUS fields
  localparam int ST_RX_VALID   = 0;
  localparam int ST_RX_ERR     = 1;
  localparam int ST_TX_BUSY    = 2;
  localparam int ST_TOOL_VALID = 3;
  localparam int ST_TOOL_BUSY  = 4;
  localparam int ST_OVERRUN    = 5;

  localparam logic [15:0] CRC_SEED = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [15:0] BCC_SEED = 16'h0000;

  typedef enum logic [1:0] {
    RSP_BAUD_LO  = 2'b00,
    RSP_BAUD_MID = 2'b01,
    RSP_BAUD_HI  = 2'b10
  } rsp_baud_t;

  typedef enum logic [1:0] {
    RSP_PAR_NONE = 2'b00,
    RSP_PAR_EVEN = 2'b01,
    RSP_PAR_ODD  = 2'b10
  } rsp_par_t;

  typedef struct packed {
    logic     data8;
    logic     stop2;
    rsp_par_t parity;
  } rsp_fmt_t;

  localparam rsp_fmt_t TOOL_FMT = '{data8: 1'b1, stop2: 1'b0, parity: RSP_PAR_NONE};

endpackage : rsp_pkg

//--- rtl/rsp_port.sv
// Shared-line serial port with setup-tool port and Avalon-MM register slave
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// One serial channel: transmitter and receiver
// ****************************************
module rsp_chan (
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  input  wire logic [rsp_pkg::DIV_W-1:0] div,
  input  wire rsp_pkg::rsp_fmt_t        fmt,
  input  wire logic                     rxd,
  input  wire logic                     tx_go,
  input  wire logic [7:0]               tx_byte,
  output logic                          tx_busy,
  output logic                          txd,
  output logic                          rx_busy,
  output logic                          rx_stb,
  output logic [7:0]                    rx_byte,
  output logic                          rx_err
);
  logic [11:0]               tsh_ff;
  logic [3:0]                tbits_ff;
  logic [rsp_pkg::DIV_W-1:0] tcnt_ff;
  logic                      txd_ff;
  logic [11:0]               rsh_ff;
  logic [3:0]                rbits_ff;
  logic [rsp_pkg::DIV_W-1:0] rcnt_ff;
  logic                      rstb_ff;
  logic [7:0]                rbyte_ff;
  logic                      rerr_ff;
  logic [3:0]                nd;
  logic                      pe;
  logic [11:0]               nxt_frame;
  logic [3:0]                nxt_len;
  logic [11:0]               algn;
  logic [7:0]                rdat;
  logic                      rpar_bad;

  always_comb begin
    nd = fmt.data8 ? 4'h8 : 4'h7;
    pe = (fmt.parity != rsp_pkg::RSP_PAR_NONE);
    nxt_frame = '1;
    nxt_frame[0] = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (i < int'(nd)) begin
        nxt_frame[1 + i] = tx_byte[i];
      end
    end
    if (pe) begin
      nxt_frame[1 + nd] = ^(tx_byte & {fmt.data8, 7'h7f}) ^ (fmt.parity == rsp_pkg::RSP_PAR_ODD);
    end
    nxt_len = 4'h1 + nd + {3'h0, pe} + (fmt.stop2 ? 4'h2 : 4'h1);
    // Received bits sit at the top of the shifter; bring the start bit to bit 0
    algn = rsh_ff >> (4'hc - (4'h2 + nd + {3'h0, pe}));
    rdat = algn[8:1] & {fmt.data8, 7'h7f};
    rpar_bad = pe && ((^rdat ^ algn[1 + nd]) != (fmt.parity == rsp_pkg::RSP_PAR_ODD));
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tsh_ff   <= '1;
      tbits_ff <= 4'h0;
      tcnt_ff  <= '0;
    end else if (tbits_ff == 4'h0) begin
      if (tx_go) begin
        tsh_ff   <= nxt_frame;
        tbits_ff <= nxt_len;
        tcnt_ff  <= div - 1'b1;
      end
    end else if (tcnt_ff == '0) begin
      tsh_ff   <= {1'b1, tsh_ff[11:1]};
      tbits_ff <= tbits_ff - 4'h1;
      tcnt_ff  <= div - 1'b1;
    end else begin
      tcnt_ff <= tcnt_ff - 1'b1;
    end
  end

  // Idle line is high between frames
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      txd_ff <= 1'b1;
    end else begin
      txd_ff <= (tbits_ff == 4'h0) | tsh_ff[0];
    end
  end

  // Receiver samples mid-bit: start, data, parity and the first stop bit
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rsh_ff   <= '0;
      rbits_ff <= 4'h0;
      rcnt_ff  <= '0;
      rstb_ff  <= 1'b0;
      rbyte_ff <= 8'h00;
      rerr_ff  <= 1'b0;
    end else begin
      rstb_ff <= 1'b0;
      if (rbits_ff == 4'h0) begin
        if (!rxd) begin
          rbits_ff <= 4'h2 + nd + {3'h0, pe};
          rcnt_ff  <= div >> 1;
        end
      end else if (rcnt_ff == '0) begin
        rsh_ff   <= {rxd, rsh_ff[11:1]};
        rcnt_ff  <= div - 1'b1;
        rbits_ff <= rbits_ff - 4'h1;
      end else begin
        rcnt_ff <= rcnt_ff - 1'b1;
      end
      // One cycle after the stop sample the frame is complete
      if (rbits_ff == 4'h1 && rcnt_ff == '0) begin
        rbits_ff <= 4'h0;
      end
      if (rbits_ff == 4'h0 && rsh_ff[11] && !rstb_ff && rcnt_ff == div - 1'b1) begin
        rstb_ff  <= 1'b1;
        rbyte_ff <= rdat;
        rerr_ff  <= algn[0] | rpar_bad;
        rcnt_ff  <= '0;
      end else if (rbits_ff == 4'h0 && !rsh_ff[11] && rcnt_ff == div - 1'b1) begin
        // Stop bit low: framing error, still delivered
        rstb_ff  <= 1'b1;
        rbyte_ff <= rdat;
        rerr_ff  <= 1'b1;
        rcnt_ff  <= '0;
      end
    end
  end

  assign tx_busy = (tbits_ff != 4'h0);
  assign txd     = txd_ff;
  assign rx_busy = (rbits_ff != 4'h0);
  assign rx_stb  = rstb_ff;
  assign rx_byte = rbyte_ff;
  assign rx_err  = rerr_ff;
endmodule : rsp_chan

// ****************************************
// Top: register slave, reply timing, two channels
// ****************************************
module rsp_port #(
  parameter int CYC_PER_MS = rsp_pkg::CYC_PER_MS
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        line_rx,
  output logic             line_tx,
  output logic             line_oe_b,
  input  wire logic        tool_rx,
  output logic             tool_tx
);
  // Millisecond prescaler must fit its 16-bit counter
  if (CYC_PER_MS < 2 || CYC_PER_MS > 65535) begin : g_bad_cyc
    $error("CYC_PER_MS out of range");
  end

  logic [1:0]  lsync_ff, tsync_ff;
  logic [31:0] cfg_ff;
  logic        ack_ff;
  logic        wreq_ff;
  logic [31:0] rdata_ff;
  logic        rxv_ff, rxerr_ff, ovr_ff, toolv_ff;
  logic [7:0]  rxb_ff, toolb_ff;
  logic        txp_ff, toolp_ff;
  logic [7:0]  txb_ff, toolt_ff;
  logic [15:0] chk_ff;
  logic [15:0] mscnt_ff;
  logic [6:0]  dly_ff;
  logic        oe_b_ff;
  logic        ltx_ff, ttx_ff;
  logic [rsp_pkg::DIV_W-1:0] div;
  rsp_pkg::rsp_fmt_t fmt;
  logic        l_busy, l_txd, l_rbusy, l_stb, l_err, t_busy, t_txd, t_stb;
  logic [7:0]  l_byte, t_byte;
  logic        acc, wr, rd, launch, tool_go;
  logic [31:0] nxt_rdata;
  logic [15:0] nxt_chk;

  assign fmt = '{data8: cfg_ff[rsp_pkg::CF_DATA8], stop2: cfg_ff[rsp_pkg::CF_STOP2],
                 parity: rsp_pkg::rsp_par_t'(cfg_ff[rsp_pkg::CF_PAR_LSB +: 2])};

  always_comb begin
    unique case (rsp_pkg::rsp_baud_t'(cfg_ff[rsp_pkg::CF_BAUD_LSB +: 2]))
      rsp_pkg::RSP_BAUD_MID: div = rsp_pkg::DIV_MID;
      rsp_pkg::RSP_BAUD_HI:  div = rsp_pkg::DIV_HI;
      default:               div = rsp_pkg::DIV_LO;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lsync_ff <= 2'b11;
      tsync_ff <= 2'b11;
    end else begin
      lsync_ff <= {lsync_ff[0], line_rx};
      tsync_ff <= {tsync_ff[0], tool_rx};
    end
  end

  // A data write is held off while the previous byte still waits
  assign acc = (avs_read | avs_write) & ~ack_ff &
               ~(avs_write & avs_address == rsp_pkg::ADDR_DATA & txp_ff) &
               ~(avs_write & avs_address == rsp_pkg::ADDR_TOOL & toolp_ff);
  assign wr  = acc & avs_write & avs_byteenable[0];
  assign rd  = acc & avs_read;

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (avs_address)
      rsp_pkg::ADDR_CONFIG: nxt_rdata = cfg_ff;
      rsp_pkg::ADDR_STATUS: nxt_rdata = {26'h0, ovr_ff, t_busy | toolp_ff, toolv_ff,
                                         l_busy | txp_ff, rxerr_ff, rxv_ff};
      rsp_pkg::ADDR_DATA:   nxt_rdata = {24'h0, rxb_ff};
      rsp_pkg::ADDR_CHECK:  nxt_rdata = {16'h0, chk_ff};
      rsp_pkg::ADDR_TOOL:   nxt_rdata = {24'h0, toolb_ff};
      default:              nxt_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_ff   <= 1'b0;
      wreq_ff  <= 1'b1;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ack_ff  <= acc;
      // Registered copy so the pin comes straight from a flop
      wreq_ff <= ~acc;
      if (rd) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_ff <= {17'h0, rsp_pkg::DELAY_RST_MS, 8'h00};
    end else if (wr && avs_address == rsp_pkg::ADDR_CONFIG) begin
      cfg_ff[6:0]   <= avs_writedata[6:0];
      // delay capped at its top value
      cfg_ff[14:8]  <= (avs_writedata[14:8] > rsp_pkg::DELAY_MAX_MS) ?
                       rsp_pkg::DELAY_MAX_MS : avs_writedata[14:8];
    end
  end

  // Received flags: hardware set wins over software clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rxv_ff <= 1'b0; rxerr_ff <= 1'b0; ovr_ff <= 1'b0;
      rxb_ff <= 8'h00; toolv_ff <= 1'b0; toolb_ff <= 8'h00;
    end else begin
      if (rd && avs_address == rsp_pkg::ADDR_DATA) rxv_ff <= 1'b0;
      if (wr && avs_address == rsp_pkg::ADDR_STATUS) begin
        if (avs_writedata[rsp_pkg::ST_RX_ERR])  rxerr_ff <= 1'b0;
        if (avs_writedata[rsp_pkg::ST_OVERRUN]) ovr_ff   <= 1'b0;
      end
      if (l_stb) begin
        rxv_ff <= 1'b1;
        rxb_ff <= l_byte;
        if (l_err) rxerr_ff <= 1'b1;
        if (rxv_ff) ovr_ff <= 1'b1;
      end
      if (rd && avs_address == rsp_pkg::ADDR_TOOL) toolv_ff <= 1'b0;
      if (t_stb) begin
        toolv_ff <= 1'b1;
        toolb_ff <= t_byte;
      end
    end
  end

  // reply delay restarts after every received character
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mscnt_ff <= 16'h0000;
      dly_ff   <= 7'h00;
    end else if (l_stb || l_rbusy) begin
      mscnt_ff <= 16'(CYC_PER_MS - 1);
      dly_ff   <= cfg_ff[rsp_pkg::CF_DELAY_LSB +: 7];
    end else if (dly_ff != 7'h00) begin
      if (mscnt_ff == 16'h0000) begin
        mscnt_ff <= 16'(CYC_PER_MS - 1);
        dly_ff   <= dly_ff - 7'h01;
      end else begin
        mscnt_ff <= mscnt_ff - 16'h0001;
      end
    end
  end

  assign launch  = txp_ff & ~l_busy & ~l_rbusy & ~l_stb & (dly_ff == 7'h00) & oe_b_ff == 1'b0;
  // tool port never waits on the shared line
  assign tool_go = toolp_ff & ~t_busy;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      txp_ff <= 1'b0; txb_ff <= 8'h00; toolp_ff <= 1'b0; toolt_ff <= 8'h00;
    end else begin
      if (launch) txp_ff <= 1'b0;
      if (wr && avs_address == rsp_pkg::ADDR_DATA) begin
        txp_ff <= 1'b1;
        txb_ff <= avs_writedata[7:0];
      end
      if (tool_go) toolp_ff <= 1'b0;
      if (wr && avs_address == rsp_pkg::ADDR_TOOL) begin
        toolp_ff <= 1'b1;
        toolt_ff <= avs_writedata[7:0];
      end
    end
  end

  // drive only while a reply is pending or going out
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      oe_b_ff <= 1'b1;
    end else begin
      oe_b_ff <= ~((txp_ff & ~l_rbusy & (dly_ff == 7'h00)) | l_busy);
    end
  end

  // message check over received and sent bytes, reflected CRC or XOR
  always_comb begin
    nxt_chk = chk_ff;
    if (wr && avs_address == rsp_pkg::ADDR_CHECK) begin
      nxt_chk = cfg_ff[rsp_pkg::CF_CRC] ? rsp_pkg::CRC_SEED : rsp_pkg::BCC_SEED;
    end
    if (l_stb || launch) begin
      if (cfg_ff[rsp_pkg::CF_CRC]) begin
        nxt_chk = nxt_chk ^ {8'h00, l_stb ? l_byte : txb_ff};
        for (int i = 0; i < 8; i++) begin
          nxt_chk = nxt_chk[0] ? ((nxt_chk >> 1) ^ rsp_pkg::CRC_POLY) : (nxt_chk >> 1);
        end
      end else begin
        nxt_chk = nxt_chk ^ {8'h00, l_stb ? l_byte : txb_ff};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      chk_ff <= rsp_pkg::BCC_SEED;
      ltx_ff <= 1'b1;
      ttx_ff <= 1'b1;
    end else begin
      chk_ff <= nxt_chk;
      ltx_ff <= l_txd;
      ttx_ff <= t_txd;
    end
  end

  rsp_chan u_line (
    .clk(clk), .rst_b(rst_b), .div(div), .fmt(fmt), .rxd(lsync_ff[1]),
    .tx_go(launch), .tx_byte(txb_ff), .tx_busy(l_busy), .txd(l_txd),
    .rx_busy(l_rbusy), .rx_stb(l_stb), .rx_byte(l_byte), .rx_err(l_err)
  );

  rsp_chan u_tool (
    .clk(clk), .rst_b(rst_b), .div(rsp_pkg::DIV_TOOL), .fmt(rsp_pkg::TOOL_FMT),
    .rxd(tsync_ff[1]), .tx_go(tool_go), .tx_byte(toolt_ff), .tx_busy(t_busy),
    .txd(t_txd), .rx_busy(), .rx_stb(t_stb), .rx_byte(t_byte), .rx_err()
  );

  assign avs_readdata    = rdata_ff;
  assign avs_waitrequest = wreq_ff;
  assign line_tx         = ltx_ff;
  assign line_oe_b       = oe_b_ff;
  assign tool_tx         = ttx_ff;
endmodule : rsp_port

`default_nettype wire

//--- tb/rs485_serial_comms_port_test.sv
// Self-checking bench for the shared-line serial port
`timescale 1ns/1ns
`default_nettype none
module rs485_serial_comms_port_test;
  localparam int MSC = 200;
  localparam int DH  = int'(rsp_pkg::DIV_HI);
  logic        clk, rst_b, avs_read, avs_write, avs_waitrequest;
  logic        line_rx, line_tx, line_oe_b, tool_tx;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable;
  int          failures, samples_checked, cycles;
  // Tool port looped back so its receiver hears its own transmitter
  rsp_port #(.CYC_PER_MS(MSC)) dut (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .line_rx(line_rx), .line_tx(line_tx),
    .line_oe_b(line_oe_b), .tool_rx(tool_tx), .tool_tx(tool_tx));
  rsp_host host (.clk(clk), .line_tx(line_tx), .line_oe_b(line_oe_b), .line_rx(line_rx));
  always #20 clk = ~clk;
  task automatic close_out();
    $display("compared %0d mismatched %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      failures = failures + 1;
      $display("[ERR] %0t run timed out", $time);
      close_out();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // ****************************************
  // Register bus and helpers
  // ****************************************
  task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : bus_wr
  task automatic bus_rd(input logic [4:0] a, output logic [31:0] d);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask : bus_rd
  task automatic wait_st(input int pos);
    logic [31:0] s;
    do bus_rd(rsp_pkg::ADDR_STATUS, s); while (s[pos] !== 1'b1);
  endtask : wait_st
  function automatic logic [31:0] cfg(logic [1:0] r, logic d8, logic s2, logic [1:0] p,
                                      logic [6:0] dly);
    return {17'h0, dly, 2'h0, p, s2, d8, r};
  endfunction : cfg
  function automatic logic [10:0] div_of(logic [1:0] r);
    return r == 2'h0 ? rsp_pkg::DIV_LO : r == 2'h1 ? rsp_pkg::DIV_MID : rsp_pkg::DIV_HI;
  endfunction : div_of
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    logic [31:0] d;
    bus_rd(rsp_pkg::ADDR_CONFIG, d);
    check(d, 32'h00001400);
    bus_wr(rsp_pkg::ADDR_CONFIG, cfg(2'h0, 1'b1, 1'b1, 2'h2, 7'h7f));
    bus_rd(rsp_pkg::ADDR_CONFIG, d);
    check(d, cfg(2'h0, 1'b1, 1'b1, 2'h2, 7'h63));
    bus_rd(5'h14, d);
    check(d, 32'h0);
  endtask : t_regs
  task automatic t_rx();
    logic [31:0] d;
    logic [7:0]  b;
    logic [1:0]  p;
    for (int i = 0; i < 3; i++) begin
      b = 8'hb5 + 8'(i);
      p = (i == 0) ? 2'h1 : (i == 1) ? 2'h2 : 2'h0;
      bus_wr(rsp_pkg::ADDR_CONFIG, cfg(2'(i), i != 0, i == 1, p, 7'h0));
      host.send(b, div_of(2'(i)), i != 0, i == 1, p);
      wait_st(rsp_pkg::ST_RX_VALID);
      bus_rd(rsp_pkg::ADDR_DATA, d);
      check(d, {24'h0, i != 0 ? b : {1'b0, b[6:0]}});
      bus_rd(rsp_pkg::ADDR_STATUS, d);
      check({31'h0, d[rsp_pkg::ST_RX_ERR]}, 32'h0);
    end
  endtask : t_rx
  task automatic t_parity();
    logic [31:0] d;
    // CRC-16 mode, reseeded, so the check word covers this one byte
    bus_wr(rsp_pkg::ADDR_CONFIG,
           cfg(2'h2, 1'b1, 1'b0, 2'h1, 7'h0) | (32'h1 << rsp_pkg::CF_CRC));
    bus_wr(rsp_pkg::ADDR_CHECK, 32'h0);
    host.send(8'h5a, rsp_pkg::DIV_HI, 1'b1, 1'b0, 2'h2);
    wait_st(rsp_pkg::ST_RX_VALID);
    bus_rd(rsp_pkg::ADDR_STATUS, d);
    check({31'h0, d[rsp_pkg::ST_RX_ERR]}, 32'h1);
    bus_wr(rsp_pkg::ADDR_STATUS, 32'h2);
    bus_rd(rsp_pkg::ADDR_DATA, d);
    bus_rd(rsp_pkg::ADDR_STATUS, d);
    check({30'h0, d[1:0]}, 32'h0);
    bus_rd(rsp_pkg::ADDR_CHECK, d);
    check(d, 32'h0000_7b3f);
  endtask : t_parity
  task automatic t_reply();
    logic [31:0] d;
    logic [7:0]  b;
    logic        ok;
    int          t0;
    bus_wr(rsp_pkg::ADDR_CONFIG, cfg(2'h2, 1'b1, 1'b1, 2'h1, 7'd10));
    bus_wr(rsp_pkg::ADDR_CHECK, 32'h0);
    host.send(8'h5a, rsp_pkg::DIV_HI, 1'b1, 1'b1, 2'h1);
    t0 = cycles;
    bus_wr(rsp_pkg::ADDR_DATA, 32'ha5);
    bus_wr(rsp_pkg::ADDR_TOOL, 32'h3c);
    while (line_oe_b !== 1'b0) @(posedge clk);
    t0 = cycles - t0;
    // Delay runs from the first stop-bit centre, 1.5 bits before the second stop ends
    check({31'h0, t0 >= 10 * MSC - 2 * DH && t0 <= 10 * MSC - DH}, 32'h1);
    host.recv(b, ok, rsp_pkg::DIV_HI, 1'b1, 1'b1, 2'h1);
    check({24'h0, b}, 32'ha5);
    check({31'h0, ok}, 32'h1);
    repeat (DH) @(posedge clk);
    check({31'h0, line_oe_b}, 32'h1);
    bus_rd(rsp_pkg::ADDR_CHECK, d);
    check(d, {16'h0, rsp_pkg::BCC_SEED ^ 16'h005a ^ 16'h00a5});
    wait_st(rsp_pkg::ST_TOOL_VALID);
    bus_rd(rsp_pkg::ADDR_TOOL, d);
    check(d, 32'h3c);
  endtask : t_reply
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    avs_address = 5'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    failures = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_regs();
    t_rx();
    t_parity();
    t_reply();
    close_out();
  end
endmodule : rs485_serial_comms_port_test
`default_nettype wire

//--- tb/rsp_host.sv
// Host master model on the shared two-wire line
`timescale 1ns/1ns
`default_nettype none
module rsp_host (
  input  wire logic clk,
  input  wire logic line_tx,
  input  wire logic line_oe_b,
  output logic      line_rx
);
  logic drv;
  logic bit_v;
  logic wire_v;
  initial begin
    drv = 1'b0;
    bit_v = 1'b1;
  end
  // bias pulls a released line high
  assign wire_v = !line_oe_b ? line_tx : (drv ? bit_v : 1'b1);
  // Device receiver hears only the host driver, so it never hears its own reply
  assign line_rx = drv ? bit_v : 1'b1;
  task automatic put(input logic v, input logic [10:0] div);
    drv <= 1'b1;
    bit_v <= v;
    repeat (div) @(posedge clk);
  endtask : put
  // wait for a free line, then send one framed character
  task automatic send(input logic [7:0] b, input logic [10:0] div, input logic d8,
                      input logic s2, input logic [1:0] p);
    while (!line_oe_b) @(posedge clk);
    put(1'b0, div);
    for (int i = 0; i < 7 + int'(d8); i++) put(b[i], div);
    if (p != 2'h0) put(^(d8 ? b : {1'b0, b[6:0]}) ^ (p == 2'h2), div);
    put(1'b1, div);
    if (s2) put(1'b1, div);
    drv <= 1'b0;
  endtask : send
  // sample a reply at bit centres and judge its framing
  task automatic recv(output logic [7:0] b, output logic ok, input logic [10:0] div,
                      input logic d8, input logic s2, input logic [1:0] p);
    b = 8'h0;
    while (wire_v !== 1'b0) @(posedge clk);
    repeat (div / 2) @(posedge clk);
    ok = (wire_v === 1'b0);
    for (int i = 0; i < 7 + int'(d8); i++) begin
      repeat (div) @(posedge clk);
      b[i] = wire_v;
    end
    if (p != 2'h0) begin
      repeat (div) @(posedge clk);
      ok = ok & (wire_v === (^b ^ (p == 2'h2)));
    end
    repeat (div) @(posedge clk);
    ok = ok & (wire_v === 1'b1);
    if (s2) begin
      repeat (div) @(posedge clk);
      ok = ok & (wire_v === 1'b1);
    end
  endtask : recv
endmodule : rsp_host
`default_nettype wire

//--- tb/rsp_port_checker.sv
// Pin and register-bus timing checks for the shared-line serial port
`timescale 1ns/1ns
`default_nettype none
module rsp_port_checker (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        avs_read,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        line_rx,
  input wire logic        line_tx,
  input wire logic        line_oe_b,
  input wire logic        tool_tx
);
  logic [15:0] low_ff;
  logic [15:0] high_ff;
  logic [15:0] tlow_ff;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ****************************************
  // Run lengths on the transmit pins
  // ****************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      low_ff <= 16'h0;
      high_ff <= 16'h0;
      tlow_ff <= 16'h0;
    end else begin
      low_ff <= line_tx ? 16'h0 : low_ff + 16'h1;
      high_ff <= line_tx ? high_ff + 16'h1 : 16'h0;
      tlow_ff <= tool_tx ? 16'h0 : tlow_ff + 16'h1;
    end
  end
  sequence answer_s;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  sequence launch_s;
    ##[1:4] $fell(line_tx);
  endsequence
  idle_high_a: assert property (line_oe_b |-> line_tx)
    else $error("line data not idle while released");
  no_talk_a: assert property (!line_rx && line_oe_b |=> line_oe_b)
    else $error("line taken while a character arrives");
  start_bit_a: assert property ($fell(line_oe_b) |-> launch_s)
    else $error("no start bit after taking the line");
  bit_width_a: assert property ($rose(line_tx) |-> low_ff >= 16'(rsp_pkg::DIV_HI))
    else $error("line bit shorter than fastest rate");
  stop_hold_a: assert property ($rose(line_oe_b) |-> high_ff >= 16'(rsp_pkg::DIV_HI))
    else $error("line released before stop bit ended");
  tool_bit_a: assert property ($rose(tool_tx) |-> tlow_ff >= 16'(rsp_pkg::DIV_TOOL))
    else $error("tool bit shorter than its fixed rate");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  read_answer_a: assert property ($rose(avs_read) |-> answer_s)
    else $error("read not answered after one wait cycle");
  read_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data changed without a read");
endmodule : rsp_port_checker
bind rsp_port rsp_port_checker chk (.clk(clk), .rst_b(rst_b), .avs_read(avs_read),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .line_rx(line_rx),
  .line_tx(line_tx), .line_oe_b(line_oe_b), .tool_tx(tool_tx));
`default_nettype wire
